// [core/dsrq_regs.svh]
// Register offsets, field layout and reset values of the software request block.
// Assumes inclusion by the package, the design modules and the bench.
// Behaviour
// RL1: Writing 1 to a burst request bit raises a burst request; 0 does nothing.
// RL2: Burst request bit reads 1 while that burst transfer runs, else 0.
// RL3: Writing 1 to a single request bit raises a single request; 0 is ignored.
// RL4: Single request bit reads 1 while that single transfer runs, else 0.
// RL5: Single request register has bits 0 to 15, bit n is request number n.
// RL6: Software must not request while hardware requests the same number.
// RL7: Software keeps burst bits at 0 for numbers without burst source.
// RL8: Software keeps single bits at 0 for numbers without single source.
// RL9: Burst request bit n maps one-to-one to request number n.
// RL10: While the global operate control is 0, registers are neither writable nor readable; the code locks out only the burst and single registers.
// RL11: Bits 31 to 16 are unused; write as 0, device ignores them.
`ifndef DSRQ_REGS_SVH
`define DSRQ_REGS_SVH
`define DSRQ_OFS_BURST 12'h000
`define DSRQ_OFS_SINGLE 12'h004
`define DSRQ_OFS_CONFIG 12'h008
`define DSRQ_CFG_OPERATE_BIT 0
`define DSRQ_REQ_RESET 16'h0000
`define DSRQ_CFG_RESET 1'b0
`define DSRQ_ADDR_MSB 11
`define DSRQ_REQ_MSB 15
`endif

// [core/dsrq_pkg.sv]
// Types shared by the software request block.
// Assumes the register header is on the include path.
`include "dsrq_regs.svh"
package dsrq_pkg;
    typedef logic [`DSRQ_REQ_MSB:0] dsrq_vec_type;
    typedef logic [`DSRQ_ADDR_MSB:0] dsrq_addr_type;
    typedef enum logic [1:0] {DSRQ_SEL_BURST, DSRQ_SEL_SINGLE, DSRQ_SEL_CONFIG, DSRQ_SEL_NONE}
        dsrq_sel_type;
endpackage : dsrq_pkg

// [core/dsrq_req_bank.sv]
// One bank of sixteen software request bits, set by software, cleared by the engine.
// Assumes done pulses come from the transfer engine on the same clock.
`timescale 1ns/1ps
`include "dsrq_regs.svh"
module dsrq_req_bank #(
    parameter int NUM_REQ = 16
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic set_en_in,
    input wire logic [NUM_REQ-1:0] set_bits_in,
    input wire logic [NUM_REQ-1:0] done_in,
    output logic [NUM_REQ-1:0] pend_out
);
    logic [NUM_REQ-1:0] pend_reg;
    logic [NUM_REQ-1:0] pend_next;
    // Ones raise a request, zeros leave it; a set in the same cycle as done wins
    assign pend_next = (pend_reg & ~done_in) | (set_en_in ? set_bits_in : '0); // [RL1] [RL3]
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pend_reg <= '0;
        end else if (clk_en_in) begin
            pend_reg <= pend_next;
        end
    end
    assign pend_out = pend_reg;

    a_set_raises: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL1]
        clk_en_in && set_en_in |=> ((pend_reg & $past(set_bits_in)) == $past(set_bits_in)))
        else $error("written request bit not raised");
    a_zero_no_clear: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL3]
        clk_en_in && ~|done_in |=> ((pend_reg & $past(pend_reg)) == $past(pend_reg)))
        else $error("request bit lost without done");
endmodule : dsrq_req_bank

// [core/dsrq_top.sv]
// Software burst and single request registers on an APB slave.
// Assumes the transfer engine pulses done per request number on mclk_in.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dsrq_regs.svh"
module dsrq_top #(
    parameter int NUM_REQ = 16
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire dsrq_pkg::dsrq_addr_type paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [NUM_REQ-1:0] burst_done_in,
    input wire logic [NUM_REQ-1:0] single_done_in,
    output logic [NUM_REQ-1:0] burst_req_out,
    output logic [NUM_REQ-1:0] single_req_out,
    output logic operate_out
);
    import dsrq_pkg::*;

    function automatic dsrq_sel_type dsrq_decode(input dsrq_addr_type a);
        case (a)
            `DSRQ_OFS_BURST: dsrq_decode = DSRQ_SEL_BURST;
            `DSRQ_OFS_SINGLE: dsrq_decode = DSRQ_SEL_SINGLE;
            `DSRQ_OFS_CONFIG: dsrq_decode = DSRQ_SEL_CONFIG;
            default: dsrq_decode = DSRQ_SEL_NONE;
        endcase
    endfunction : dsrq_decode

    logic operate_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [NUM_REQ-1:0] burst_pend;
    logic [NUM_REQ-1:0] single_pend;
    logic [31:0] rdata_next;

    wire dsrq_sel_type sel = dsrq_decode(paddr_in);
    wire access_ph = psel_in && penable_in && !pready_reg;
    // Request registers are locked out while the controller is stopped
    wire req_sel = (sel == DSRQ_SEL_BURST) || (sel == DSRQ_SEL_SINGLE);
    wire blocked = req_sel && !operate_reg; // [RL10]
    wire bad_acc = (sel == DSRQ_SEL_NONE) || blocked;
    wire wr_ok = access_ph && pwrite_in && !bad_acc;
    wire low_lanes = pstrb_in[0] || pstrb_in[1];
    // Upper half of write data is never looked at
    wire [NUM_REQ-1:0] wr_bits = pwdata_in[NUM_REQ-1:0]; // [RL11]
    wire burst_wr = wr_ok && (sel == DSRQ_SEL_BURST) && low_lanes; // [RL9]
    wire single_wr = wr_ok && (sel == DSRQ_SEL_SINGLE) && low_lanes; // [RL5]
    wire cfg_wr = wr_ok && (sel == DSRQ_SEL_CONFIG) && pstrb_in[0];

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (sel)
            DSRQ_SEL_BURST: if (operate_reg) rdata_next[NUM_REQ-1:0] = burst_pend; // [RL2]
            DSRQ_SEL_SINGLE: if (operate_reg) rdata_next[NUM_REQ-1:0] = single_pend; // [RL4]
            DSRQ_SEL_CONFIG: rdata_next[`DSRQ_CFG_OPERATE_BIT] = operate_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    dsrq_req_bank #(.NUM_REQ(NUM_REQ)) u_burst (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .set_en_in(burst_wr),
        .set_bits_in(wr_bits),
        .done_in(burst_done_in),
        .pend_out(burst_pend)
    );

    dsrq_req_bank #(.NUM_REQ(NUM_REQ)) u_single (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .set_en_in(single_wr),
        .set_bits_in(wr_bits),
        .done_in(single_done_in),
        .pend_out(single_pend)
    );

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            operate_reg <= `DSRQ_CFG_RESET;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (clk_en_in) begin
            pready_reg <= access_ph;
            pslverr_reg <= access_ph && bad_acc;
            prdata_reg <= (access_ph && !pwrite_in && !bad_acc) ? rdata_next : 32'h0000_0000;
            if (cfg_wr) begin
                operate_reg <= pwdata_in[`DSRQ_CFG_OPERATE_BIT];
            end
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign burst_req_out = burst_pend;
    assign single_req_out = single_pend;
    assign operate_out = operate_reg;

    // Refusal while stopped and read-back of the pending levels
    a_stopped_no_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL10]
        clk_en_in && !operate_reg && ~|burst_done_in && ~|single_done_in
        |=> $stable(burst_req_out) && $stable(single_req_out))
        else $error("request written while stopped");
    a_stopped_read_err: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL10]
        clk_en_in && access_ph && req_sel && !operate_reg
        |=> pready_out && pslverr_out && prdata_out == 32'h0000_0000)
        else $error("stopped access not refused");
    a_burst_readback: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL2]
        clk_en_in && access_ph && !pwrite_in && sel == DSRQ_SEL_BURST && operate_reg
        |=> prdata_out == {16'h0000, $past(burst_pend)})
        else $error("burst read mismatch");
    a_single_readback: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL4]
        clk_en_in && access_ph && !pwrite_in && sel == DSRQ_SEL_SINGLE && operate_reg
        |=> prdata_out == {16'h0000, $past(single_pend)})
        else $error("single read mismatch");
    a_burst_map: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL9]
        clk_en_in && burst_wr |=> (burst_req_out & $past(wr_bits)) == $past(wr_bits))
        else $error("burst bit to request mismatch");
    a_single_map: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL5]
        clk_en_in && single_wr |=> (single_req_out & $past(wr_bits)) == $past(wr_bits))
        else $error("single bit to request mismatch");
    a_ready_one: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        clk_en_in && psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
        else $error("pready not one cycle");
    a_upper_ignored: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL11]
        clk_en_in && access_ph && !pwrite_in |=> prdata_out[31:16] == 16'h0000)
        else $error("upper bits not zero");

    // Writes of zero, engine completion and spontaneous changes of the pending levels
    a_burst_zero_keep: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL1]
        clk_en_in && burst_wr && ~|burst_done_in
        |=> (burst_req_out & $past(burst_req_out)) == $past(burst_req_out))
        else $error("burst write cleared a pending bit");
    a_single_zero_keep: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL3]
        clk_en_in && single_wr && ~|single_done_in
        |=> (single_req_out & $past(single_req_out)) == $past(single_req_out))
        else $error("single write cleared a pending bit");
    a_burst_no_raise: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL1]
        clk_en_in && !burst_wr && ~|burst_done_in
        |=> $stable(burst_req_out))
        else $error("burst request changed without write or done");
    a_single_no_raise: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL3]
        clk_en_in && !single_wr && ~|single_done_in
        |=> $stable(single_req_out))
        else $error("single request changed without write or done");
    a_burst_done_clear: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL2]
        clk_en_in && !burst_wr && |burst_done_in
        |=> (burst_req_out & $past(burst_done_in)) == {NUM_REQ{1'b0}})
        else $error("burst request kept after done");
    a_single_done_clear: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL4]
        clk_en_in && !single_wr && |single_done_in
        |=> (single_req_out & $past(single_done_in)) == {NUM_REQ{1'b0}})
        else $error("single request kept after done");

    // Bus answer shape
    a_error_with_ready: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        pslverr_out
        |-> pready_out)
        else $error("pslverr without pready");
    a_idle_rdata_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !pready_out
        |-> prdata_out == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_error_rdata_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RL10]
        pslverr_out
        |-> prdata_out == 32'h0000_0000)
        else $error("refused access returned data");
    a_unmapped_err: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        clk_en_in && access_ph && sel == DSRQ_SEL_NONE
        |=> pready_out && pslverr_out)
        else $error("unmapped access not refused");
    a_config_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        clk_en_in && cfg_wr
        |=> operate_out == $past(pwdata_in[`DSRQ_CFG_OPERATE_BIT]))
        else $error("operate bit not written");

    // Reset clears and a low clock enable holds every output
    a_reset_clears: assert property (@(posedge mclk_in)
        sys_rst_in
        |=> !pready_out && !pslverr_out && prdata_out == 32'h0000_0000 && !operate_out
            && burst_req_out == {NUM_REQ{1'b0}} && single_req_out == {NUM_REQ{1'b0}})
        else $error("outputs not cleared by reset");
    a_freeze_ready: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(pready_out))
        else $error("pready moved while frozen");
    a_freeze_error: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(pslverr_out))
        else $error("pslverr moved while frozen");
    a_freeze_rdata: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(prdata_out))
        else $error("read data moved while frozen");
    a_freeze_operate: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(operate_out))
        else $error("operate bit moved while frozen");
    a_freeze_burst: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(burst_req_out))
        else $error("burst request moved while frozen");
    a_freeze_single: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !clk_en_in
        |=> $stable(single_req_out))
        else $error("single request moved while frozen");
endmodule : dsrq_top

// [verification/dsrq_engine_model.sv]
// Transfer engine stand-in: finishes each pending request with a one-cycle done pulse.
// Assumes the request levels come from the block on the same clock; hold_in stalls it.
`timescale 1ns/1ps
module dsrq_engine_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic hold_in,
    input wire logic [15:0] burst_req_in,
    input wire logic [15:0] single_req_in,
    output logic [15:0] burst_done_out,
    output logic [15:0] single_done_out
);
    // No hardware request line is modelled, so none meets a software one
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || hold_in) begin
            burst_done_out <= 16'h0000;
            single_done_out <= 16'h0000;
        end else begin
            burst_done_out <= burst_req_in & ~burst_done_out;
            single_done_out <= single_req_in & ~single_done_out;
        end
    end
endmodule : dsrq_engine_model

// [verification/tb.sv]
// Self-checking bench for the software request registers over APB.
// Assumes one wait state per access; the engine model ends requests once released.
`timescale 1ns/1ps
`include "dsrq_regs.svh"
module tb;
    import dsrq_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b1;
    logic en = 1'b1;
    dsrq_addr_type paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, operate, e;
    logic [15:0] b_req, s_req, b_done, s_done;
    int err_count = 0, n_tests = 0, cyc = 0;
    always #20 mclk = ~mclk;
    dsrq_top #(.NUM_REQ(16)) i_dsrq_top (.mclk_in(mclk), .sys_rst_in(sys_rst),
        .clk_en_in(en), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .burst_done_in(b_done),
        .single_done_in(s_done), .burst_req_out(b_req), .single_req_out(s_req),
        .operate_out(operate));
    dsrq_engine_model i_dsrq_engine_model (.mclk_in(mclk), .sys_rst_in(sys_rst),
        .hold_in(hold), .burst_req_in(b_req), .single_req_in(s_req),
        .burst_done_out(b_done), .single_done_out(s_done));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input dsrq_addr_type a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && cyc < 2000);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b1, `DSRQ_OFS_BURST, 32'h1);
        chk("locked error", 32'h1, {31'h0, e});
        chk("locked request", 32'h0, {16'h0, b_req});
        apb(1'b0, `DSRQ_OFS_BURST, 32'h0);
        chk("locked read", 32'h0, q);
        $display("test locked done");
        apb(1'b1, `DSRQ_OFS_CONFIG, 32'h1);
        chk("operate", 32'h1, {31'h0, operate});
        // Only bits with a source are set; upper bits test that they are ignored
        apb(1'b1, `DSRQ_OFS_BURST, 32'hffff_0181);
        chk("burst out", 32'h181, {16'h0, b_req});
        apb(1'b1, `DSRQ_OFS_BURST, 32'h0);
        chk("burst kept", 32'h181, {16'h0, b_req});
        apb(1'b0, `DSRQ_OFS_BURST, 32'h0);
        chk("burst running", 32'h181, q);
        apb(1'b1, `DSRQ_OFS_SINGLE, 32'h8001);
        chk("single out", 32'h8001, {16'h0, s_req});
        apb(1'b1, `DSRQ_OFS_SINGLE, 32'h0);
        apb(1'b0, `DSRQ_OFS_SINGLE, 32'h0);
        chk("single running", 32'h8001, q);
        $display("test running done");
        apb(1'b1, `DSRQ_OFS_CONFIG, 32'h0);
        apb(1'b0, `DSRQ_OFS_BURST, 32'h0);
        chk("stopped read", 32'h0, q);
        chk("stopped read error", 32'h1, {31'h0, e});
        apb(1'b1, `DSRQ_OFS_SINGLE, 32'h2);
        chk("stopped write", 32'h8001, {16'h0, s_req});
        apb(1'b1, `DSRQ_OFS_CONFIG, 32'h1);
        $display("test lockout done");
        en <= 1'b0;
        hold <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("frozen request", 32'h181, {16'h0, b_req});
        en <= 1'b1;
        $display("test frozen done");
        apb(1'b0, `DSRQ_OFS_BURST, 32'h0);
        chk("burst stopped", 32'h0, q);
        apb(1'b0, `DSRQ_OFS_SINGLE, 32'h0);
        chk("single stopped", 32'h0, q);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("test stopped done");
        conclude();
    end
endmodule : tb
